// file: hdl/psam_map.sv
// Program space address map: table and window routes
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module psam_map
  import psam_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Core request
  input  wire psam_req_t   core_req,
  output logic [15:0]      core_rdata,
  output logic             core_done,
  output logic [1:0]       core_extra,
  // Program counter
  input  wire logic        pc_advance,
  output logic [23:0]      pc,
  // Program memory
  output logic [23:0]      prog_addr,
  output logic             prog_rd,
  output logic             prog_wr,
  output logic [23:0]      prog_wdata,
  output logic [2:0]       prog_wmask,
  input  wire logic [23:0] prog_rdata,
  // Data memory
  output logic [15:0]      data_addr,
  output logic             data_rd,
  output logic             data_wr,
  output logic [15:0]      data_wdata,
  input  wire logic [15:0] data_rdata
);

  logic [15:0] core_control;
  logic [7:0]  table_page;
  logic [7:0]  window_page;
  logic [3:0]  aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;
  logic        table_busy;
  logic        window_enable;
  logic        window_hit;
  logic        table_hit;
  logic [1:0]  next_extra;
  logic [15:0] next_rdata;
  logic [1:0]  wait_cnt;
  logic        busy;
  logic        rd_pend;
  logic [15:0] rd_hold;

  typedef enum logic [1:0] {PSAM_IDLE, PSAM_WAIT, PSAM_DONE} psam_state_t;
  psam_state_t state;

  // AXI write channel
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_bresp   = (aw_addr == REG_STATUS) ? 2'h2 : 2'h0;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      core_control <= CORE_CTRL_RST;
      table_page   <= TABLE_PAGE_RST;
      window_page  <= WINDOW_PAGE_RST;
    end else if (aw_held && w_held) begin
      case (aw_addr)
        REG_CORE_CONTROL: begin
          if (w_strb[0]) core_control[7:0] <= w_data[7:0];
          if (w_strb[1]) core_control[15:8] <= w_data[15:8];
        end
        REG_TABLE_PAGE: if (w_strb[0]) table_page <= w_data[7:0];
        REG_WINDOW_PAGE: if (w_strb[0]) window_page <= w_data[7:0];
        default: ;
      endcase
    end
  end

  // AXI read channel
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      case (s_axi_araddr)
        REG_CORE_CONTROL: s_axi_rdata <= {16'h0, core_control};
        REG_TABLE_PAGE:   s_axi_rdata <= {24'h0, table_page};
        REG_WINDOW_PAGE:  s_axi_rdata <= {24'h0, window_page};
        REG_STATUS:       s_axi_rdata <= {28'h0, table_busy, busy,
                                          window_enable, rd_pend};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Route decode
  assign window_enable = core_control[WINDOW_EN_BIT];
  assign table_hit  = core_req.op == PSAM_OP_TABLE;
  assign table_busy = table_hit || (busy && rd_pend);
  assign window_hit = core_req.op == PSAM_OP_DATA && core_req.ea[15]
                      && window_enable && !table_busy && !core_req.write;

  // Program and data addressing
  always_comb begin
    prog_addr  = 24'h0;
    prog_rd    = 1'b0;
    prog_wr    = 1'b0;
    prog_wdata = 24'h0;
    prog_wmask = 3'h0;
    data_addr  = core_req.ea;
    data_rd    = 1'b0;
    data_wr    = 1'b0;
    data_wdata = core_req.wdata;
    if (state == PSAM_IDLE) begin
      if (table_hit) begin
        prog_addr = {table_page, core_req.ea};
        prog_rd   = !core_req.write;
        prog_wr   = core_req.write;
        if (core_req.high_half) begin
          prog_wdata = {core_req.wdata[7:0], 16'h0};
          prog_wmask = 3'h4;
        end else if (core_req.byte_mode) begin
          prog_wdata = {8'h0, core_req.wdata[7:0], core_req.wdata[7:0]};
          prog_wmask = core_req.ea[0] ? 3'h2 : 3'h1;
        end else begin
          prog_wdata = {8'h0, core_req.wdata};
          prog_wmask = 3'h3;
        end
      end else if (window_hit) begin
        prog_addr = {1'b0, window_page, core_req.ea[14:0]};
        prog_rd   = 1'b1;
      end else if (core_req.op == PSAM_OP_DATA) begin
        data_rd = !core_req.write;
        data_wr = core_req.write;
      end
    end
  end

  // Read lane selection
  always_comb begin
    next_rdata = data_rdata;
    if (table_hit) begin
      if (!core_req.high_half) begin
        if (!core_req.byte_mode)
          next_rdata = prog_rdata[15:0];
        else if (core_req.ea[0])
          next_rdata = {8'h0, prog_rdata[15:8]};
        else
          next_rdata = {8'h0, prog_rdata[7:0]};
      end else if (core_req.byte_mode && core_req.ea[0]) begin
        next_rdata = 16'h0;
      end else begin
        next_rdata = {8'h0, prog_rdata[23:16]};
      end
    end else if (window_hit) begin
      next_rdata = prog_rdata[15:0];
    end
  end

  // Extra cycle count
  always_comb begin
    next_extra = 2'h0;
    if (window_hit) begin
      if (core_req.in_repeat)
        next_extra = core_req.repeat_edge ? EXTRA_LONG : 2'h0;
      else
        next_extra = core_req.move_instr ? EXTRA_SHORT : EXTRA_LONG;
    end
  end

  // Completion sequencing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state      <= PSAM_IDLE;
      wait_cnt   <= 2'h0;
      core_rdata <= 16'h0;
      core_extra <= 2'h0;
      rd_hold    <= 16'h0;
      rd_pend    <= 1'b0;
      busy       <= 1'b0;
    end else begin
      case (state)
        PSAM_IDLE: begin
          if (core_req.op != PSAM_OP_NONE) begin
            rd_hold    <= next_rdata;
            core_extra <= next_extra;
            wait_cnt   <= next_extra;
            rd_pend    <= table_hit;
            busy       <= 1'b1;
            state      <= (next_extra == 2'h0) ? PSAM_DONE : PSAM_WAIT;
            if (next_extra == 2'h0) core_rdata <= next_rdata;
          end
        end
        PSAM_WAIT: begin
          wait_cnt <= wait_cnt - 2'h1;
          if (wait_cnt == 2'h1) begin
            core_rdata <= rd_hold;
            state      <= PSAM_DONE;
          end
        end
        PSAM_DONE: begin
          busy    <= 1'b0;
          rd_pend <= 1'b0;
          state   <= PSAM_IDLE;
        end
        default: state <= PSAM_IDLE;
      endcase
    end
  end
  assign core_done = state == PSAM_DONE;

  // Program counter
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      pc <= 24'h0;
    else if (pc_advance)
      pc <= pc + PC_STEP;
  end

  // Address construction; program address is only driven in idle
  a_table_addr: assert property (@(posedge clk) disable iff (!resetn)
    (state == PSAM_IDLE && table_hit)
      |-> prog_addr == {table_page, core_req.ea})
    else $error("table address wrong");
  a_table_space: assert property (@(posedge clk) disable iff (!resetn)
    (state == PSAM_IDLE && table_hit)
      |-> prog_addr[23] == table_page[CONFIG_SEL_BIT])
    else $error("table space select wrong");
  a_window_addr: assert property (@(posedge clk) disable iff (!resetn)
    (state == PSAM_IDLE && window_hit)
      |-> prog_addr == {1'b0, window_page, core_req.ea[14:0]})
    else $error("window address wrong");
  a_window_user: assert property (@(posedge clk) disable iff (!resetn)
    (state == PSAM_IDLE && window_hit) |-> !prog_addr[23])
    else $error("window reached configuration space");
  a_window_b15: assert property (@(posedge clk) disable iff (!resetn)
    (state == PSAM_IDLE && window_hit) |-> prog_addr[15] == window_page[0])
    else $error("window address bit 15 wrong");
  a_window_page: assert property (@(posedge clk) disable iff (!resetn)
    (state == PSAM_IDLE && window_hit) |-> prog_addr[22:15] == window_page)
    else $error("window page not applied");
  a_window_gate: assert property (@(posedge clk) disable iff (!resetn)
    window_hit |-> core_req.ea[15] && core_control[2] && !table_hit)
    else $error("window used without enable");
  a_table_first: assert property (@(posedge clk) disable iff (!resetn)
    table_busy |-> !window_hit)
    else $error("window open during table access");
  a_upper_lane: assert property (@(posedge clk) disable iff (!resetn)
    (prog_wr && prog_wmask[2]) |-> table_hit && core_req.high_half)
    else $error("upper program byte written outside high access");

  // Read lanes
  a_table_word: assert property (@(posedge clk) disable iff (!resetn)
    (table_hit && !core_req.high_half && !core_req.byte_mode)
      |-> next_rdata == prog_rdata[15:0])
    else $error("word low table read wrong");
  a_table_byte: assert property (@(posedge clk) disable iff (!resetn)
    (table_hit && !core_req.high_half && core_req.byte_mode)
      |-> next_rdata[15:8] == 8'h0 && next_rdata[7:0] ==
          (core_req.ea[0] ? prog_rdata[15:8] : prog_rdata[7:0]))
    else $error("byte low table read wrong");
  a_phantom_zero: assert property (@(posedge clk) disable iff (!resetn)
    (table_hit && core_req.high_half) |-> next_rdata[15:8] == 8'h0)
    else $error("phantom byte not zero");
  a_table_high: assert property (@(posedge clk) disable iff (!resetn)
    (table_hit && core_req.high_half && !core_req.byte_mode)
      |-> next_rdata == {8'h0, prog_rdata[23:16]})
    else $error("word high table read wrong");
  a_phantom_byte: assert property (@(posedge clk) disable iff (!resetn)
    (table_hit && core_req.high_half && core_req.byte_mode && core_req.ea[0])
      |-> next_rdata == 16'h0)
    else $error("phantom byte read not zero");
  a_window_data: assert property (@(posedge clk) disable iff (!resetn)
    window_hit |-> next_rdata == prog_rdata[15:0])
    else $error("window read not lower word");
  a_no_redirect: assert property (@(posedge clk) disable iff (!resetn)
    (state == PSAM_IDLE && core_req.op == PSAM_OP_DATA && !core_req.ea[15])
      |-> !prog_rd && next_extra == 2'h0)
    else $error("plain access redirected");
  a_window_off: assert property (@(posedge clk) disable iff (!resetn)
    (state == PSAM_IDLE && core_req.op == PSAM_OP_DATA && !window_enable)
      |-> !prog_rd && data_rd == !core_req.write)
    else $error("access redirected while window disabled");

  // Cycle counts
  a_window_slow: assert property (@(posedge clk) disable iff (!resetn)
    (state == PSAM_IDLE && window_hit && !core_req.in_repeat) |=> !core_done)
    else $error("window read took no extra cycle");
  a_move_extra: assert property (@(posedge clk) disable iff (!resetn)
    (state == PSAM_IDLE && window_hit && !core_req.in_repeat
      && core_req.move_instr) |=> state == PSAM_WAIT ##1 state == PSAM_DONE)
    else $error("move window timing wrong");
  a_other_extra: assert property (@(posedge clk) disable iff (!resetn)
    (state == PSAM_IDLE && window_hit && !core_req.in_repeat
      && !core_req.move_instr)
      |=> state == PSAM_WAIT [*2] ##1 state == PSAM_DONE)
    else $error("window timing wrong");
  a_repeat_fast: assert property (@(posedge clk) disable iff (!resetn)
    (state == PSAM_IDLE && window_hit && core_req.in_repeat
      && !core_req.repeat_edge) |=> core_done)
    else $error("repeat iteration slow");
  a_repeat_edge: assert property (@(posedge clk) disable iff (!resetn)
    (state == PSAM_IDLE && window_hit && core_req.in_repeat
      && core_req.repeat_edge)
      |=> state == PSAM_WAIT [*2] ##1 state == PSAM_DONE)
    else $error("repeat edge iteration timing wrong");
  a_plain_fast: assert property (@(posedge clk) disable iff (!resetn)
    (state == PSAM_IDLE && core_req.op == PSAM_OP_DATA && !window_hit)
      |=> core_done && core_extra == 2'h0)
    else $error("plain access slowed");
  a_pc_step: assert property (@(posedge clk) disable iff (!resetn)
    pc_advance |=> pc == $past(pc) + PC_STEP)
    else $error("pc step wrong");

  // Coverage
  c_window_read: cover property (@(posedge clk) disable iff (!resetn)
    window_hit && !core_req.in_repeat);
  c_table_high: cover property (@(posedge clk) disable iff (!resetn)
    table_hit && core_req.high_half && !core_req.write);
  c_repeat_edge: cover property (@(posedge clk) disable iff (!resetn)
    window_hit && core_req.in_repeat && core_req.repeat_edge);
  c_reg_write: cover property (@(posedge clk) disable iff (!resetn)
    aw_held && w_held && aw_addr == REG_WINDOW_PAGE);
  c_table_write: cover property (@(posedge clk) disable iff (!resetn)
    prog_wr && prog_wmask == 3'h4);

endmodule : psam_map
`default_nettype wire

// file: hdl/psam_pkg.sv
// Package for the program space address map block
package psam_pkg;
  localparam logic [3:0] REG_CORE_CONTROL = 4'h0;
  localparam logic [3:0] REG_TABLE_PAGE   = 4'h4;
  localparam logic [3:0] REG_WINDOW_PAGE  = 4'h8;
  localparam logic [3:0] REG_STATUS       = 4'hc;
  localparam int         WINDOW_EN_BIT    = 2;
  localparam int         CONFIG_SEL_BIT   = 7;
  localparam logic [7:0] TABLE_PAGE_RST   = 8'h00;
  localparam logic [7:0] WINDOW_PAGE_RST  = 8'h00;
  localparam logic [15:0] CORE_CTRL_RST   = 16'h0000;
  localparam logic [1:0] EXTRA_SHORT      = 2'h1;
  localparam logic [1:0] EXTRA_LONG       = 2'h2;
  localparam logic [23:0] PC_STEP         = 24'h000002;

  typedef enum logic [1:0] {
    PSAM_OP_NONE, PSAM_OP_DATA, PSAM_OP_TABLE
  } psam_op_t;

  typedef struct packed {
    psam_op_t    op;
    logic        high_half;
    logic        byte_mode;
    logic        write;
    logic        move_instr;
    logic        in_repeat;
    logic        repeat_edge;
    logic [15:0] ea;
    logic [15:0] wdata;
  } psam_req_t;
endpackage : psam_pkg

// file: verification/psam_mem_model.sv
// Program and data memory model on the far side of the address map
`timescale 1ns/1ps
`default_nettype none
module psam_mem_model (
  // Program memory
  input  wire logic [23:0] prog_addr,
  input  wire logic        prog_rd,
  output logic [23:0]      prog_rdata,
  // Data memory
  input  wire logic [15:0] data_addr,
  input  wire logic        data_rd,
  output logic [15:0]      data_rdata
);
  // Upper byte all ones or all zeros, so stray execution is harmless
  function automatic logic [23:0] pat(input logic [23:0] a);
    return {{8{^a}}, a[15:0] ^ {a[23:16], a[23:16]} ^ 16'h5a3c};
  endfunction
  function automatic logic [15:0] dpat(input logic [15:0] a);
    return a ^ 16'h9e37;
  endfunction
  // Unselected memories show inverted contents, never a stale match
  assign prog_rdata = prog_rd ? pat(prog_addr) : ~pat(prog_addr);
  assign data_rdata = data_rd ? dpat(data_addr) : ~dpat(data_addr);
endmodule // psam_mem_model
`default_nettype wire

// file: verification/tb.sv
// Self-checking testbench for the program space address map
`timescale 1ns/1ps
`default_nettype none
module tb;
  import psam_pkg::*;
  logic        clk, resetn, pc_advance;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, core_done, prog_rd, prog_wr;
  logic        data_rd, data_wr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp, core_extra;
  logic [2:0]  prog_wmask;
  logic [15:0] core_rdata, data_addr, data_wdata, data_rdata;
  logic [23:0] pc, prog_addr, prog_wdata, prog_rdata;
  psam_req_t   core_req;
  int          fail_count, samples_checked;
  logic [18:0] expq[$];
  logic [18:0] exp_item;

  psam_map dut (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .core_req, .core_rdata, .core_done, .core_extra, .pc_advance, .pc,
    .prog_addr, .prog_rd, .prog_wr, .prog_wdata, .prog_wmask, .prog_rdata,
    .data_addr, .data_rd, .data_wr, .data_wdata, .data_rdata);
  psam_mem_model mem (.prog_addr, .prog_rd, .prog_rdata, .data_addr,
    .data_rd, .data_rdata);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1'b1;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp === er, "write response");
  endtask

  task automatic axr(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata === d && s_axi_rresp === er, "register read");
  endtask

  // Request is held until completion, then dropped until the next request
  task automatic core(input psam_op_t op, input logic hi, bm, mv, ir, re,
                      input logic [15:0] ea, e, input logic [1:0] ex);
    @(posedge clk);
    expq.push_back({1'b0, ex, e});
    core_req <= '{op, hi, bm, 1'b0, mv, ir, re, ea, 16'($urandom)};
    repeat (60) begin
      @(posedge clk);
      if (core_done) break;
    end
    core_req.op <= PSAM_OP_NONE;
  endtask

  // Write request; strobes and lanes are looked at while the request stands
  task automatic cw(input psam_op_t op, input logic hi, bm,
                    input logic [15:0] ea, d, input logic [7:0] pg);
    logic [2:0]  m;
    logic [23:0] w, k;
    m = hi ? 3'h4 : (bm ? (ea[0] ? 3'h2 : 3'h1) : 3'h3);
    w = hi ? {d[7:0], 16'h0} : (bm ? {8'h0, d[7:0], d[7:0]} : {8'h0, d});
    k = {{8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
    @(posedge clk);
    expq.push_back({1'b1, 18'h0});
    core_req <= '{op, hi, bm, 1'b1, 1'b0, 1'b0, 1'b0, ea, d};
    @(posedge clk);
    if (op == PSAM_OP_TABLE) begin
      chk(prog_wr === 1'b1 && prog_addr === {pg, ea}, "table write");
      chk(prog_rd === 1'b0 && data_wr === 1'b0, "table write strobes");
      chk(prog_wmask === m, "write lane mask");
      chk((prog_wdata & k) === (w & k), "write lane data");
    end else begin
      chk(data_wr === 1'b1 && prog_rd === 1'b0 && prog_wr === 1'b0,
          "window range write");
      chk(data_addr === ea && data_wdata === d, "data write lanes");
    end
    repeat (60) begin
      @(posedge clk);
      if (core_done) break;
    end
    core_req.op <= PSAM_OP_NONE;
  endtask

  always @(posedge clk) begin
    if (core_done === 1'b1) begin
      if (expq.size() == 0) chk(1'b0, "completion without request");
      else begin
        exp_item = expq.pop_front();
        chk(core_extra === exp_item[17:16]
            && (exp_item[18] || core_rdata === exp_item[15:0]), "core result");
      end
    end
  end

  initial begin
    #300us;
    fail_count++;
    final_report;
  end

  initial begin
    logic [7:0]  pg;
    logic [15:0] ea, e;
    logic [23:0] p;
    logic [1:0]  ex;
    int          n;
    resetn = 1'b0; pc_advance = 1'b0; core_req = '0; s_axi_wstrb = 4'hf;
    s_axi_awaddr = '0; s_axi_awvalid = 1'b0; s_axi_wdata = '0;
    s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_araddr = '0;
    s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
    void'($urandom(32'hb56d87d8));
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    axr(REG_CORE_CONTROL, 32'h0, 2'b00);
    axr(REG_TABLE_PAGE, 32'h0, 2'b00);
    axr(REG_WINDOW_PAGE, 32'h0, 2'b00);
    axr(REG_STATUS, 32'h0, 2'b00);
    axr(4'h2, 32'h0, 2'b10);
    axw(REG_STATUS, 32'hf, 2'b10);
    // Table reads in all four modes, both spaces, window on and off
    for (int i = 0; i < 32; i++) begin
      pg = {i[3], 7'($urandom)};
      ea = 16'($urandom) | {i[2], 15'h0};
      axw(REG_TABLE_PAGE, {24'h0, pg}, 2'b00);
      axr(REG_TABLE_PAGE, {24'h0, pg}, 2'b00);
      axw(REG_CORE_CONTROL, 32'(i[2]) << WINDOW_EN_BIT, 2'b00);
      p = mem.pat({pg, ea});
      case (i[1:0])
        2'd0: e = p[15:0];
        2'd1: e = ea[0] ? {8'h0, p[15:8]} : {8'h0, p[7:0]};
        2'd2: e = {8'h0, p[23:16]};
        default: e = ea[0] ? 16'h0 : {8'h0, p[23:16]};
      endcase
      core(PSAM_OP_TABLE, i[1], i[0], 1'b0, 1'b0, 1'b0, ea, e, 2'h0);
    end
    // Window reads with every kind of instruction and loop position
    axw(REG_CORE_CONTROL, 32'h1 << WINDOW_EN_BIT, 2'b00);
    for (int i = 0; i < 24; i++) begin
      pg = 8'($urandom);
      ea = 16'($urandom) | 16'h8000;
      axw(REG_WINDOW_PAGE, {24'h0, pg}, 2'b00);
      p = mem.pat({1'b0, pg, ea[14:0]});
      ex = i[1] ? (i[2] ? EXTRA_LONG : 2'h0) : (i[0] ? EXTRA_SHORT : EXTRA_LONG);
      core(PSAM_OP_DATA, 1'b0, 1'b0, i[0], i[1], i[2], ea, p[15:0], ex);
    end
    // Ordinary data reads: window off, or lower half of data space
    for (int i = 0; i < 8; i++) begin
      ea = 16'($urandom) & (i[0] ? 16'h7fff : 16'hffff);
      axw(REG_CORE_CONTROL, 32'(i[0]) << WINDOW_EN_BIT, 2'b00);
      core(PSAM_OP_DATA, 1'b0, 1'b0, i[1], i[2], 1'b0, ea, mem.dpat(ea), 2'h0);
    end
    // Table writes in each lane mode, then writes in the window range
    axw(REG_CORE_CONTROL, 32'h1 << WINDOW_EN_BIT, 2'b00);
    for (int i = 0; i < 8; i++) begin
      pg = 8'($urandom);
      ea = 16'($urandom);
      e  = 16'($urandom);
      axw(REG_TABLE_PAGE, {24'h0, pg}, 2'b00);
      cw(PSAM_OP_TABLE, i[1], i[0], ea, e, pg);
      cw(PSAM_OP_DATA, 1'b0, 1'b0, ea | 16'h8000, e, pg);
    end
    // Program counter stepping
    n = 1 + ($urandom % 40);
    @(posedge clk);
    pc_advance <= 1'b1;
    repeat (n) @(posedge clk);
    pc_advance <= 1'b0;
    @(posedge clk);
    chk(pc === 24'(n) * PC_STEP, "program counter");
    repeat (4) @(posedge clk);
    final_report;
  end
endmodule // tb
`default_nettype wire
